// *** lssc_cmd.sv ***
// settings command interpreter with axi4-lite status and control
`include "lssc_params.svh"
module lssc_cmd
  import lssc_pkg::*;
#(
  parameter int ENERGY_W = 20,
  parameter int WIDTH_W = 13
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  input wire logic keySwitchOn,
  input wire logic extControlOn,
  input wire logic maintModeOn,
  input wire logic laserShot,
  input wire logic [ENERGY_W-1:0] shotEnergy,
  input wire logic [WIDTH_W-1:0] shotWidth,
  output lssc_mon_rec_t monRec,
  output logic monRecValid,
  input wire logic monRecReady,
  output lssc_method_t method,
  output lssc_switches_t switches,
  output logic [7:0] scheduleNumber,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic isDigit(input logic [7:0] c);
    return (c >= `LSSC_CHR_ZERO) && (c <= `LSSC_CHR_NINE);
  endfunction : isDigit

  function automatic logic [13:0] digitVal(input logic [7:0] c);
    return {10'h000, 4'(c - `LSSC_CHR_ZERO)};
  endfunction : digitVal

  // a switch field may hold 0, 1 or space only
  function automatic logic switchOk(input logic [7:0] c);
    return (c == `LSSC_CHR_ZERO) || (c == `LSSC_CHR_ONE) || (c == `LSSC_CHR_SPC);
  endfunction : switchOk

  function automatic logic switchNext(input logic [7:0] c, input logic cur);
    logic r;
    r = cur;
    if (c == `LSSC_CHR_ZERO)
    begin
      r = 1'b0;
    end
    else if (c == `LSSC_CHR_ONE)
    begin
      r = 1'b1;
    end
    return r;
  endfunction : switchNext

  lssc_state_t state_reg;
  logic [7:0] frame_reg [0:18];
  logic [4:0] count_reg;
  logic hostSel_reg;
  logic nak_reg;
  logic [6:0] unit_reg;
  logic [15:0] monInt_reg;
  logic [15:0] monCnt_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [31:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // frame decode
  logic codeMatch;
  logic unitMatch;
  logic schedBlank;
  logic schedDigits;
  logic [13:0] schedVal;
  logic [7:0] cntChr;
  logic cntOk;
  logic fieldsOk;
  logic cmdOk;
  logic [13:0] unitVal;
  lssc_method_t methodNext;

  always_comb
  begin
    codeMatch = (frame_reg[`LSSC_IDX_CODE_HI] == `LSSC_CODE_HI)
      && (frame_reg[`LSSC_IDX_CODE_LO] == `LSSC_CODE_LO);
    unitVal = digitVal(frame_reg[`LSSC_IDX_UNIT_T]) * 14'h000a
      + digitVal(frame_reg[`LSSC_IDX_UNIT_U]);
    unitMatch = isDigit(frame_reg[`LSSC_IDX_UNIT_T]) && isDigit(frame_reg[`LSSC_IDX_UNIT_U])
      && (unitVal == {7'h00, unit_reg});
    schedBlank = 1'b1;
    schedDigits = 1'b1;
    schedVal = 14'h0000;
    for (int i = 0; i < 4; i++)
    begin
      schedBlank = schedBlank && (frame_reg[`LSSC_IDX_SCHED + 5'(i)] == `LSSC_CHR_SPC);
      schedDigits = schedDigits && isDigit(frame_reg[`LSSC_IDX_SCHED + 5'(i)]);
      schedVal = 14'(schedVal * 14'h000a) + digitVal(frame_reg[`LSSC_IDX_SCHED + 5'(i)]);
    end
    cntChr = frame_reg[`LSSC_IDX_CNT];
    // any method request is refused in maintenance; only 0 or 2 otherwise
    cntOk = (cntChr == `LSSC_CHR_SPC) || (!maintModeOn
      && ((cntChr == `LSSC_CHR_ZERO) || (cntChr == `LSSC_CHR_TWO)));
    fieldsOk = switchOk(frame_reg[`LSSC_IDX_MON]);
    for (int i = 0; i < `LSSC_SW_FIELDS; i++)
    begin
      // spare fields must stay blank or the whole command is refused
      if ((i == `LSSC_SW_SPARE_A) || (i == `LSSC_SW_SPARE_B) || (i == `LSSC_SW_SPARE_C))
      begin
        fieldsOk = fieldsOk && (frame_reg[`LSSC_IDX_SW + 5'(i)] == `LSSC_CHR_SPC);
      end
      else
      begin
        fieldsOk = fieldsOk && switchOk(frame_reg[`LSSC_IDX_SW + 5'(i)]);
      end
    end
    cmdOk = cntOk && fieldsOk && (schedBlank
      || (schedDigits && (schedVal <= `LSSC_SCHED_MAX)));
  end

  // method follows from host choice, external state and maintenance mode only
  always_comb
  begin
    if (maintModeOn)
    begin
      methodNext = LSSC_M_MAINT;
    end
    else if (extControlOn)
    begin
      methodNext = hostSel_reg ? LSSC_M_EXT_HOST : LSSC_M_EXT_PANEL;
    end
    else
    begin
      methodNext = hostSel_reg ? LSSC_M_HOST : LSSC_M_PANEL;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      method <= LSSC_M_PANEL;
    end
    else if (clkEn)
    begin
      method <= methodNext;
    end
  end

  // receive and framing
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= LSSC_S_IDLE;
      count_reg <= 5'h00;
      nak_reg <= 1'b0;
      txValid <= 1'b0;
      txData <= 8'h00;
    end
    else if (clkEn)
    begin
      case (state_reg)
        LSSC_S_IDLE:
        begin
          if (rxValid && (rxData == `LSSC_CHR_STX))
          begin
            state_reg <= LSSC_S_COLLECT;
            count_reg <= 5'h00;
          end
        end
        LSSC_S_COLLECT:
        begin
          if (rxValid)
          begin
            if (rxData == `LSSC_CHR_STX)
            begin
              count_reg <= 5'h00;
            end
            else if (rxData == `LSSC_CHR_ETX)
            begin
              state_reg <= (count_reg == `LSSC_FRAME_LEN) ? LSSC_S_EVAL : LSSC_S_IDLE;
            end
            else if (count_reg == `LSSC_FRAME_LEN)
            begin
              state_reg <= LSSC_S_IDLE;
            end
            else
            begin
              count_reg <= count_reg + 5'h01;
            end
          end
        end
        LSSC_S_EVAL:
        begin
          nak_reg <= !cmdOk;
          // no reply unless host control was in force
          if (codeMatch && unitMatch && (method == LSSC_M_HOST))
          begin
            state_reg <= LSSC_S_REPLY0;
            txValid <= 1'b1;
            txData <= cmdOk ? `LSSC_CHR_ACK : `LSSC_CHR_NAK;
          end
          else
          begin
            state_reg <= LSSC_S_IDLE;
          end
        end
        LSSC_S_REPLY0:
        begin
          if (txReady)
          begin
            state_reg <= LSSC_S_REPLY1;
            txData <= frame_reg[`LSSC_IDX_UNIT_T];
          end
        end
        LSSC_S_REPLY1:
        begin
          if (txReady)
          begin
            state_reg <= LSSC_S_REPLY2;
            txData <= frame_reg[`LSSC_IDX_UNIT_U];
          end
        end
        LSSC_S_REPLY2:
        begin
          if (txReady)
          begin
            state_reg <= LSSC_S_IDLE;
            txValid <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= LSSC_S_IDLE;
        end
      endcase
    end
  end

  // frames arriving during a reply are dropped, no buffering
  always_ff @(posedge sys_clk)
  begin
    if (clkEn && (state_reg == LSSC_S_COLLECT) && rxValid && (count_reg < `LSSC_FRAME_LEN))
    begin
      frame_reg[count_reg] <= rxData;
    end
  end

  // apply settings, all or nothing
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hostSel_reg <= 1'b0;
      switches <= '0;
      scheduleNumber <= 8'h00;
    end
    else if (clkEn)
    begin
      if ((state_reg == LSSC_S_EVAL) && codeMatch && unitMatch && cmdOk)
      begin
        if (!schedBlank)
        begin
          scheduleNumber <= schedVal[7:0];
        end
        if (cntChr != `LSSC_CHR_SPC)
        begin
          hostSel_reg <= (cntChr == `LSSC_CHR_TWO);
        end
        switches.laserDiodeOn <= switchNext(frame_reg[`LSSC_IDX_SW], switches.laserDiodeOn);
        switches.guideLightOn <= switchNext(frame_reg[`LSSC_IDX_SW + `LSSC_SW_GUIDE],
          switches.guideLightOn);
        for (int i = 0; i < 4; i++)
        begin
          switches.shutterOpen[i] <= switchNext(frame_reg[`LSSC_IDX_SW + `LSSC_SW_SHUT + 5'(i)],
            switches.shutterOpen[i]);
        end
        // only reset or a 0 in the monitor field clears reporting; method changes leave it
        switches.monitorReportOn <= switchNext(frame_reg[`LSSC_IDX_MON],
          switches.monitorReportOn);
      end
      else if (!keySwitchOn && !extControlOn && !maintModeOn)
      begin
        hostSel_reg <= 1'b0;
      end
    end
  end

  // monitor record after each output, rate limited
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      monRec <= '0;
      monRecValid <= 1'b0;
      monCnt_reg <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (monCnt_reg != 16'h0000)
      begin
        monCnt_reg <= monCnt_reg - 16'h0001;
      end
      if (monRecValid && monRecReady)
      begin
        monRecValid <= 1'b0;
      end
      else if (laserShot && switches.monitorReportOn && !monRecValid && (monCnt_reg == 16'h0000))
      begin
        monRecValid <= 1'b1;
        monCnt_reg <= monInt_reg;
        monRec.scheduleNumber <= scheduleNumber;
        monRec.energyCentiJoule <= 20'(shotEnergy);
        monRec.waveCount <= `LSSC_WAVE_COUNT;
        monRec.pulseWidthDeciMs <= 13'(shotWidth);
      end
    end
  end

  // axi4-lite write channel
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 32'h0000_0000;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LSSC_RESP_OKAY;
      unit_reg <= `LSSC_RST_UNIT;
      monInt_reg <= `LSSC_RST_MONINT;
    end
    else if (clkEn)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      else if (awHeld_reg && wHeld_reg && !s_axi_bvalid)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `LSSC_RESP_OKAY;
        if (awAddr_reg[7:0] == `LSSC_OFF_UNIT)
        begin
          if (wStrb_reg[0])
          begin
            unit_reg <= wData_reg[6:0];
          end
        end
        else if (awAddr_reg[7:0] == `LSSC_OFF_MONINT)
        begin
          if (wStrb_reg[0])
          begin
            monInt_reg[7:0] <= wData_reg[7:0];
          end
          if (wStrb_reg[1])
          begin
            monInt_reg[15:8] <= wData_reg[15:8];
          end
        end
        else if ((awAddr_reg[7:0] != `LSSC_OFF_STATE) && (awAddr_reg[7:0] != `LSSC_OFF_SCHED))
        begin
          s_axi_bresp <= `LSSC_RESP_SLVERR;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (clkEn)
    begin
      s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // axi4-lite read channel, one cycle latency
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LSSC_RESP_OKAY;
    end
    else if (clkEn)
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `LSSC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr[7:0] == `LSSC_OFF_UNIT)
        begin
          s_axi_rdata <= {25'h0000000, unit_reg};
        end
        else if (s_axi_araddr[7:0] == `LSSC_OFF_STATE)
        begin
          s_axi_rdata <= {21'h000000, nak_reg, switches, method};
        end
        else if (s_axi_araddr[7:0] == `LSSC_OFF_SCHED)
        begin
          s_axi_rdata <= {24'h000000, scheduleNumber};
        end
        else if (s_axi_araddr[7:0] == `LSSC_OFF_MONINT)
        begin
          s_axi_rdata <= {16'h0000, monInt_reg};
        end
        else
        begin
          s_axi_rresp <= `LSSC_RESP_SLVERR;
        end
      end
    end
  end
endmodule : lssc_cmd

// *** lssc_cmd_assertions.sv ***
// concurrent checks on the settings command interpreter ports
`include "lssc_params.svh"
module lssc_cmd_assertions
  import lssc_pkg::*;
(
  input logic sys_clk,
  input logic sys_rst,
  input logic keySwitchOn,
  input logic extControlOn,
  input logic maintModeOn,
  input logic txValid,
  input logic [7:0] txData,
  input logic txReady,
  input lssc_mon_rec_t monRec,
  input logic monRecValid,
  input logic monRecReady,
  input lssc_method_t method
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] gapCnt;
  // saturates so a long idle never wraps into a short gap
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      gapCnt <= 8'hff;
    else if ($rose(monRecValid))
      gapCnt <= 8'h00;
    else if (gapCnt != 8'hff)
      gapCnt <= gapCnt + 8'h01;
  end
  sequence s_key_released;
    (!keySwitchOn && !extControlOn && !maintModeOn) [*4];
  endsequence
  sequence s_ext_held;
    (extControlOn && !maintModeOn) [*3];
  endsequence
  a_key_off_panel:
    assert property (s_key_released |-> method == LSSC_M_PANEL)
      else $error("method not panel after key off");
  a_ext_selects:
    assert property (s_ext_held |-> method inside {LSSC_M_EXT_PANEL, LSSC_M_EXT_HOST})
      else $error("external control not in force");
  a_ext_to_host:
    assert property ($rose(extControlOn) && method == LSSC_M_HOST && !maintModeOn
      |-> ##[1:2] method == LSSC_M_EXT_HOST) else $error("host not mapped to five");
  a_ext_off_host:
    assert property ($fell(extControlOn) && method == LSSC_M_EXT_HOST && !maintModeOn
      && keySwitchOn |-> ##[1:2] method == LSSC_M_HOST) else $error("five not back to two");
  a_ext_off_panel:
    assert property ($fell(extControlOn) && method == LSSC_M_EXT_PANEL && !maintModeOn
      |-> ##[1:2] method == LSSC_M_PANEL) else $error("one not back to zero");
  a_maint_forces:
    assert property (maintModeOn [*3] |-> method == LSSC_M_MAINT)
      else $error("maintenance not held");
  a_method_legal:
    assert property (method inside {LSSC_M_PANEL, LSSC_M_EXT_PANEL, LSSC_M_HOST,
      LSSC_M_MAINT, LSSC_M_EXT_HOST}) else $error("method code illegal");
  a_reply_host:
    assert property ($rose(txValid) |-> $past(method) == LSSC_M_HOST)
      else $error("reply outside host control");
  a_tx_hold:
    assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("reply byte not held");
  a_wave_count:
    assert property (monRecValid |-> monRec.waveCount == `LSSC_WAVE_COUNT)
      else $error("wave count wrong");
  a_rec_hold:
    assert property (monRecValid && !monRecReady |=> monRecValid && $stable(monRec))
      else $error("record not held");
  a_rec_spacing:
    assert property ($rose(monRecValid) |-> gapCnt >= 8'h64)
      else $error("records too close");
endmodule : lssc_cmd_assertions
bind lssc_cmd lssc_cmd_assertions u_chk (.sys_clk, .sys_rst, .keySwitchOn, .extControlOn,
  .maintModeOn, .txValid, .txData, .txReady, .monRec, .monRecValid, .monRecReady, .method);

// *** lssc_host_model.sv ***
// host computer model: sends command frames, collects replies
`include "lssc_params.svh"
module lssc_host_model
(
  input logic sys_clk,
  input logic slowMode,
  output logic rxValid,
  output logic [7:0] rxData,
  input logic txValid,
  input logic [7:0] txData,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] reply[$];
  logic [1:0] stallCnt = 2'h0;
  initial
  begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
  end
  // slow mode takes one byte in four so held reply bytes get seen
  always @(posedge sys_clk)
  begin
    stallCnt <= stallCnt + 2'h1;
    txReady <= !slowMode || (stallCnt == 2'h3);
    if (txValid && txReady)
      reply.push_back(txData);
  end
  task automatic put_byte(input logic [7:0] b);
    rxValid <= 1'b1;
    rxData <= b;
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxData <= ~b; // no stale byte on an idle line
    @(posedge sys_clk);
  endtask : put_byte
  // callers blank unused fields with spaces
  task automatic send_frame(input string body);
    reply.delete();
    put_byte(`LSSC_CHR_STX);
    foreach (body[i])
      put_byte(body[i]);
    put_byte(`LSSC_CHR_ETX);
  endtask : send_frame
endmodule : lssc_host_model

// *** lssc_params.svh ***
// constants for the laser state set command block
`ifndef LSSC_PARAMS_SVH
`define LSSC_PARAMS_SVH
`define LSSC_CHR_STX 8'h02
`define LSSC_CHR_ETX 8'h03
`define LSSC_CHR_ACK 8'h06
`define LSSC_CHR_NAK 8'h15
`define LSSC_CHR_SPC 8'h20
`define LSSC_CHR_ZERO 8'h30
`define LSSC_CHR_ONE 8'h31
`define LSSC_CHR_TWO 8'h32
`define LSSC_CHR_NINE 8'h39
`define LSSC_CODE_HI 8'h57
`define LSSC_CODE_LO 8'h53
`define LSSC_FRAME_LEN 5'h13
`define LSSC_IDX_CODE_HI 5'h00
`define LSSC_IDX_CODE_LO 5'h01
`define LSSC_IDX_UNIT_T 5'h02
`define LSSC_IDX_UNIT_U 5'h03
`define LSSC_IDX_SCHED 5'h04
`define LSSC_IDX_CNT 5'h08
`define LSSC_IDX_SW 5'h09
`define LSSC_IDX_MON 5'h12
`define LSSC_SW_GUIDE 5'h01
`define LSSC_SW_SPARE_A 5'h02
`define LSSC_SW_SHUT 5'h03
`define LSSC_SW_SPARE_B 5'h07
`define LSSC_SW_SPARE_C 5'h08
`define LSSC_SW_FIELDS 5'h09
`define LSSC_SCHED_MAX 14'h00ff
`define LSSC_WAVE_COUNT 8'h64
`define LSSC_OFF_UNIT 32'h0000_0000
`define LSSC_OFF_STATE 32'h0000_0004
`define LSSC_OFF_SCHED 32'h0000_0008
`define LSSC_OFF_MONINT 32'h0000_000c
`define LSSC_RST_UNIT 7'h00
`define LSSC_RST_MONINT 16'h0064
`define LSSC_RESP_OKAY 2'h0
`define LSSC_RESP_SLVERR 2'h2
`endif

// *** lssc_pkg.sv ***
// types shared by the laser state set command block
package lssc_pkg;
  typedef enum logic [2:0]
  {
    LSSC_M_PANEL = 3'h0,
    LSSC_M_EXT_PANEL = 3'h1,
    LSSC_M_HOST = 3'h2,
    LSSC_M_MAINT = 3'h3,
    LSSC_M_EXT_HOST = 3'h5
  } lssc_method_t;

  typedef enum logic [5:0]
  {
    LSSC_S_IDLE = 6'h01,
    LSSC_S_COLLECT = 6'h02,
    LSSC_S_EVAL = 6'h04,
    LSSC_S_REPLY0 = 6'h08,
    LSSC_S_REPLY1 = 6'h10,
    LSSC_S_REPLY2 = 6'h20
  } lssc_state_t;

  typedef struct packed {
    logic laserDiodeOn;
    logic guideLightOn;
    logic [3:0] shutterOpen;
    logic monitorReportOn;
  } lssc_switches_t;

  typedef struct packed {
    logic [7:0] scheduleNumber;
    logic [19:0] energyCentiJoule;
    logic [7:0] waveCount;
    logic [12:0] pulseWidthDeciMs;
  } lssc_mon_rec_t;
endpackage : lssc_pkg

// *** test_laser_state_set_command.sv ***
// self-checking bench for the settings command interpreter
`include "lssc_params.svh"
module test_laser_state_set_command
  import lssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    string body;
    logic ext;
    lssc_method_t m;
    logic [6:0] sw;
    logic [7:0] sch;
    logic [7:0] rep;
  } lssc_row_t;
  lssc_row_t rows[10];
  logic sys_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, keySwitchOn = 1'b1;
  logic extControlOn = 1'b0, maintModeOn = 1'b0, laserShot = 1'b0, monRecReady = 1'b1;
  logic slowMode = 1'b0, rxValid, txValid, txReady, monRecValid;
  logic [19:0] shotEnergy = 20'h00000;
  logic [12:0] shotWidth = 13'h0000;
  logic [7:0] rxData, txData, scheduleNumber;
  lssc_mon_rec_t monRec;
  lssc_method_t method;
  lssc_switches_t switches;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int mismatches = 0, totalChecks = 0, cycleCount = 0, recCount = 0;
  lssc_cmd u_dut (.sys_clk, .sys_rst, .clkEn, .rxValid, .rxData, .txValid, .txData, .txReady,
    .keySwitchOn, .extControlOn, .maintModeOn, .laserShot, .shotEnergy, .shotWidth, .monRec,
    .monRecValid, .monRecReady, .method, .switches, .scheduleNumber, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lssc_host_model u_host (.sys_clk, .slowMode, .rxValid, .rxData, .txValid, .txData, .txReady);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycleCount <= cycleCount + 1;
    if (monRecValid && monRecReady)
      recCount <= recCount + 1;
    if (cycleCount == 6000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic check_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_reply(input logic [7:0] rep);
    check_word("reply bytes", (rep == 8'h00) ? 3'h0 : 3'h3, u_host.reply.size());
    if (rep != 8'h00 && u_host.reply.size() == 3)
    begin
      check_word("reply code", rep, u_host.reply[0]);
      check_word("reply unit", 16'h3035, {u_host.reply[1], u_host.reply[2]});
    end
  endtask : check_reply
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic frame(input string body);
    u_host.send_frame({"WS05", body});
    tick(40);
  endtask : frame
  task automatic shot();
    laserShot <= 1'b1;
    tick(1);
    laserShot <= 1'b0;
  endtask : shot
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    @(posedge sys_clk);
  endtask : axi_write
  task automatic axi_read(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge sys_clk);
  endtask : axi_read
  initial
  begin
    rows[0] = '{"    2          ", 1'b0, LSSC_M_HOST, 7'h00, 8'h00, 8'h00};
    rows[1] = '{"0012 10 1001  1", 1'b0, LSSC_M_HOST, 7'h53, 8'h0c, 8'h06};
    rows[2] = '{"0256 01 0110   ", 1'b0, LSSC_M_HOST, 7'h53, 8'h0c, 8'h15};
    rows[3] = '{"     01 1111   ", 1'b0, LSSC_M_HOST, 7'h3f, 8'h0c, 8'h06};
    rows[4] = '{"    3          ", 1'b0, LSSC_M_HOST, 7'h3f, 8'h0c, 8'h15};
    rows[5] = '{"0255  0 0000   ", 1'b0, LSSC_M_HOST, 7'h01, 8'hff, 8'h06};
    rows[6] = '{"    0          ", 1'b0, LSSC_M_PANEL, 7'h01, 8'hff, 8'h06};
    rows[7] = '{"    2          ", 1'b0, LSSC_M_HOST, 7'h01, 8'hff, 8'h00};
    rows[8] = '{"    0          ", 1'b1, LSSC_M_EXT_PANEL, 7'h01, 8'hff, 8'h00};
    rows[9] = '{"    2          ", 1'b1, LSSC_M_EXT_HOST, 7'h01, 8'hff, 8'h00};
    tick(16);
    sys_rst <= 1'b0;
    tick(2);
    check_word("method", LSSC_M_PANEL, method);
    check_word("switches", 7'h00, switches);
    axi_read(`LSSC_OFF_MONINT);
    check_word("interval", 32'h64, rd);
    axi_read(32'h10);
    check_word("rresp", `LSSC_RESP_SLVERR, rsp);
    axi_write(32'h10, 32'h1);
    check_word("bresp", `LSSC_RESP_SLVERR, rsp);
    axi_write(`LSSC_OFF_STATE, 32'hffff_ffff);
    axi_write(`LSSC_OFF_UNIT, 32'h5);
    axi_read(`LSSC_OFF_UNIT);
    check_word("unit", 32'h5, rd);
    u_host.send_frame({"WS07", "    2          "});
    tick(40);
    u_host.send_frame({"WX05", "    2          "});
    tick(40);
    check_word("method", LSSC_M_PANEL, method);
    slowMode <= 1'b1;
    foreach (rows[i])
    begin
      extControlOn <= rows[i].ext;
      tick(4);
      frame(rows[i].body);
      check_reply(rows[i].rep);
      check_word("method", rows[i].m, method);
      check_word("switches", rows[i].sw, switches);
      check_word("schedule", rows[i].sch, scheduleNumber);
    end
    axi_read(`LSSC_OFF_STATE);
    check_word("state", 32'h0000_000d, rd);
    axi_read(`LSSC_OFF_SCHED);
    check_word("sched reg", 32'hff, rd);
    extControlOn <= 1'b0;
    tick(4);
    check_word("method", LSSC_M_HOST, method);
    frame("    0          ");
    extControlOn <= 1'b1;
    tick(4);
    check_word("method", LSSC_M_EXT_PANEL, method);
    extControlOn <= 1'b0;
    tick(4);
    check_word("method", LSSC_M_PANEL, method);
    frame("    2          ");
    keySwitchOn <= 1'b0;
    tick(6);
    check_word("method", LSSC_M_PANEL, method);
    keySwitchOn <= 1'b1;
    maintModeOn <= 1'b1;
    tick(4);
    check_word("method", LSSC_M_MAINT, method);
    frame("    2          ");
    check_reply(8'h00);
    maintModeOn <= 1'b0;
    tick(4);
    check_word("method", LSSC_M_PANEL, method);
    monRecReady <= 1'b0;
    shotEnergy <= 20'h01234;
    shotWidth <= 13'h0123;
    shot();
    tick(5);
    check_word("record", {8'hff, 20'h01234, `LSSC_WAVE_COUNT, 13'h0123}, monRec);
    check_word("record held", 1'b1, monRecValid);
    monRecReady <= 1'b1;
    tick(2);
    shot();
    tick(10);
    check_word("records", 32'h1, recCount);
    tick(110);
    shot();
    tick(5);
    check_word("records", 32'h2, recCount);
    // frozen block must ignore a shot (not yet due, as the rate counter halts too) and a whole frame
    clkEn <= 1'b0;
    tick(100);
    shot();
    frame("    2          ");
    clkEn <= 1'b1;
    tick(2);
    check_word("frozen records", 32'h2, recCount);
    check_word("frozen method", LSSC_M_PANEL, method);
    print_verdict();
  end
endmodule : test_laser_state_set_command
